// ### gate_seq_assertions.sv
// Checker for bridge 0 static sequencing and PWM side options.
// Assumes bound to the sequencer top; config static around chip-select.
`timescale 1ns/1ps
module gate_seq_checker
   import gate_seq_pkg::*;
(
   input wire logic        core_clk,
   input wire logic        rst_n,
   input wire logic        chipSelect,
   input wire logic        charge_pump_on,
   input wire logic [2:0]  bridge_pwm_select,
   input wire logic [11:0] static_gate_current_code,
   input wire logic [1:0]  gate_control_scheme,
   input wire logic [2:0]  active_freewheel_en,
   input wire logic        pwm_input_count_sel,
   input drive_kind_t      highKind [3],
   input drive_kind_t      lowKind  [3],
   input wire logic [5:0]  highStep [3],
   input wire logic [5:0]  lowStep  [3],
   input wire logic [2:0]  ccpInsert,
   input wire logic [2:0]  prechargeActive,
   input wire logic [2:0]  busy
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   logic [5:0] s0;
   logic       hiOn;
   logic       bothSink;
   assign s0 = {static_gate_current_code[3:0], 2'h0};
   assign hiOn = highKind[0] == DRV_CHARGE && lowKind[0] == DRV_SINK;
   assign bothSink = highKind[0] == DRV_SINK && lowKind[0] == DRV_SINK;
   chk_static_step: assert property (hiOn && lowStep[0] == 6'h3F |-> highStep[0] == s0)
      else $error("static step wrong");
   chk_hard_off: assert property (hiOn |-> lowStep[0] inside {6'h3F, 6'h0F, 6'h14})
      else $error("off side not hard sink");
   chk_hold_on: assert property (hiOn && lowStep[0] != 6'h3F |->
      highStep[0] == lowStep[0] && highStep[0] inside {6'h0F, 6'h14})
      else $error("hold step wrong");
   chk_ccp_sink: assert property (bothSink && !(highStep[0] inside {6'h0F, 6'h14}) |->
      highStep[0] == s0 && lowStep[0] == s0)
      else $error("protection sink wrong");
   chk_both_hold: assert property (bothSink && !busy[0] && !$past(busy[0]) |->
      highStep[0] inside {6'h0F, 6'h14} && lowStep[0] == highStep[0])
      else $error("both-off hold wrong");
   chk_pump_off: assert property (!charge_pump_on [*4] |->
      highKind[0] == DRV_PASSIVE && lowKind[0] == DRV_PASSIVE)
      else $error("gate driven with pump off");
   chk_cs_latency: assert property ($rose(chipSelect) && charge_pump_on && !bridge_pwm_select[0]
      |-> ##[1:120] busy[0])
      else $error("command not taken in time");
   chk_no_precharge: assert property ((gate_control_scheme == 2'h0) [*4] |->
      prechargeActive == 3'h0)
      else $error("pre-charge with scheme zero");
   chk_pwm_no_ccp: assert property ((bridge_pwm_select[1] && !active_freewheel_en[1]) [*4] |->
      !ccpInsert[1])
      else $error("protection without free-wheel");
   chk_afw_one_side: assert property ((bridge_pwm_select[1] && active_freewheel_en[1] &&
      !pwm_input_count_sel && charge_pump_on) [*4] |->
      (highKind[1] == DRV_CHARGE) != (lowKind[1] == DRV_CHARGE))
      else $error("free-wheel side not opposite");
   cover property (bothSink && !busy[0]);
   cover property (hiOn && lowStep[0] == 6'h3F);
   cover property (!charge_pump_on [*4]);
endmodule
bind half_bridge_gate_sequencer gate_seq_checker u_gate_seq_checker (
   .core_clk(core_clk), .rst_n(rst_n), .chipSelect(chipSelect),
   .charge_pump_on(charge_pump_on), .bridge_pwm_select(bridge_pwm_select),
   .static_gate_current_code(static_gate_current_code),
   .gate_control_scheme(gate_control_scheme), .active_freewheel_en(active_freewheel_en),
   .pwm_input_count_sel(pwm_input_count_sel),
   .highKind(highKind), .lowKind(lowKind), .highStep(highStep), .lowStep(lowStep),
   .ccpInsert(ccpInsert), .prechargeActive(prechargeActive), .busy(busy));

// ### gate_seq_pkg.sv
// Types shared by the half-bridge gate sequencer modules.
// Assumes nothing of its surroundings.
package gate_seq_pkg;
   // Gate drive: kind of drive; the current step is a separate 6-bit signal
   typedef enum logic [2:0] {
      DRV_PASSIVE = 3'h0,
      DRV_CHARGE  = 3'h1,
      DRV_SINK    = 3'h2
   } drive_kind_t;
   typedef enum logic [4:0] {
      ST_IDLE  = 5'b00001,
      ST_CCP   = 5'b00010,
      ST_BLANK = 5'b00100,
      ST_HOLD  = 5'b01000,
      ST_PWM   = 5'b10000
   } seq_state_t;
endpackage

// ### gate_seq_regs.svh
// Constants for the half-bridge gate sequencer: codes, steps and timing.
// Assumes inclusion by the design modules only, not by the package.
`ifndef GATE_SEQ_REGS_SVH
`define GATE_SEQ_REGS_SVH
`define CLK_MHZ            40
`define SYNC_DELAY_NS      3000
`define SYNC_DELAY_CYC     ((`SYNC_DELAY_NS * `CLK_MHZ) / 1000)
`define STEP_BASE_CODE     4'h6
`define STEP_BASE          6'h18
`define STEP_PER_CODE      6'h04
`define HOLD_STEP_LO       6'h0F
`define HOLD_STEP_HI       6'h14
`define HARD_OFF_STEP      6'h3F
`define MODE_PASSIVE       2'h0
`define MODE_LS_ON         2'h1
`define MODE_HS_ON         2'h2
`define MODE_BOTH_OFF      2'h3
`define AGC_NONE           2'h0
`define AGC_FIXED          2'h1
`define DUR_W              8
`endif

// ### half_bridge_gate_sequencer.sv
// Top of the three half-bridge gate sequencer.
// Assumes configuration ports are static around a chip-select rising edge.
`timescale 1ns/1ps
`include "gate_seq_regs.svh"
module half_bridge_gate_sequencer
   import gate_seq_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   input  wire logic        chipSelect,
   input  wire logic        charge_pump_on,
   input  wire logic [5:0]  half_bridge_drive_select,
   input  wire logic [2:0]  bridge_pwm_select,
   input  wire logic [11:0] static_gate_current_code,
   input  wire logic        hold_current_select,
   input  wire logic        active_side_detect_en,
   input  wire logic [1:0]  gate_control_scheme,
   input  wire logic [2:0]  active_freewheel_en,
   input  wire logic        pwm_input_count_sel,
   input  wire logic [17:0] precharge_init_current,
   input  wire logic [17:0] predischarge_init_current,
   input  wire logic [7:0]  ccpTime,
   input  wire logic [7:0]  blankTime,
   input  wire logic [7:0]  drain_source_filter_time,
   input  wire logic [5:0]  pwmIn,
   input  wire logic [2:0]  switchNodeAbove,
   input  wire logic [2:0]  switchNodeBelow,
   output gate_seq_pkg::drive_kind_t highKind [3],
   output gate_seq_pkg::drive_kind_t lowKind  [3],
   output logic [5:0]       highStep [3],
   output logic [5:0]       lowStep  [3],
   output logic [2:0]       ccpInsert,
   output logic [2:0]       prechargeActive,
   output logic [2:0]       busy
);
   import gate_seq_pkg::*;
   logic csMeta, csSync, csPrev;
   logic [5:0] pwmMeta, pwmSync;
   logic [2:0] aboveMeta, aboveSync, belowMeta, belowSync;
   logic csRise;
   logic [5:0] holdStep;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         // Chip-select idles high, so a high reset value avoids a false rise after reset
         csMeta <= 1'b1;
         csSync <= 1'b1;
         csPrev <= 1'b1;
         pwmMeta <= 6'h00;
         pwmSync <= 6'h00;
         aboveMeta <= 3'h0;
         aboveSync <= 3'h0;
         belowMeta <= 3'h0;
         belowSync <= 3'h0;
      end else begin
         csMeta <= chipSelect;
         csSync <= csMeta;
         csPrev <= csSync;
         pwmMeta <= pwmIn;
         pwmSync <= pwmMeta;
         aboveMeta <= switchNodeAbove;
         aboveSync <= aboveMeta;
         belowMeta <= switchNodeBelow;
         belowSync <= belowMeta;
      end
   end
   assign csRise = csSync & ~csPrev;
   assign holdStep = hold_current_select ? `HOLD_STEP_HI : `HOLD_STEP_LO;

   genvar b;
   generate
      for (b = 0; b < 3; b++) begin : g_bridge
         seq_state_t stateReg;
         logic [1:0] modeReg, prevModeReg;
         logic timerLoad;
         logic [`DUR_W:0] timerValue;
         logic timerDone;
         logic [5:0] staticStep;
         logic pwmHs, pwmLs, preAct;
         logic [5:0] preStep;
         logic [3:0] code;
         logic [1:0] mode;
         logic pwmMode;
         assign code = static_gate_current_code[4*b +: 4];
         assign mode = half_bridge_drive_select[2*b +: 2];
         assign pwmMode = bridge_pwm_select[b];
         // Codes below 0110 keep the same linear spacing down to step 0
         assign staticStep = 6'(code) * `STEP_PER_CODE;

         pwm_side_select u_side (
            .core_clk           (core_clk),
            .rst_n              (rst_n),
            .pwmHigh            (pwmSync[2*b]),
            .pwmLow             (pwmSync[2*b+1]),
            .swAbove            (aboveSync[b]),
            .swBelow            (belowSync[b]),
            .activeSideDetectEn (active_side_detect_en),
            .freewheelEn        (active_freewheel_en[b] & pwmMode),
            .pwmCountSel        (pwm_input_count_sel),
            .gateControlScheme  (gate_control_scheme),
            .prechargeInit      (precharge_init_current[6*b +: 6]),
            .predischargeInit   (predischarge_init_current[6*b +: 6]),
            .hsOn               (pwmHs),
            .lsOn               (pwmLs),
            .preActive          (preAct),
            .preStep            (preStep)
         );

         phase_timer u_timer (
            .core_clk  (core_clk),
            .rst_n     (rst_n),
            .load      (timerLoad),
            .loadValue (timerValue),
            .done      (timerDone)
         );

         always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
               stateReg <= ST_IDLE;
               modeReg <= `MODE_PASSIVE;
               prevModeReg <= `MODE_PASSIVE;
               timerLoad <= 1'b0;
               timerValue <= '0;
            end else begin
               timerLoad <= 1'b0;
               if (!charge_pump_on) begin
                  stateReg <= ST_IDLE;
                  modeReg <= `MODE_PASSIVE;
               end else if (pwmMode) begin
                  stateReg <= ST_PWM;
               end else if (csRise) begin
                  prevModeReg <= modeReg;
                  modeReg <= mode;
                  timerLoad <= 1'b1;
                  if (mode == `MODE_PASSIVE) begin
                     stateReg <= ST_IDLE;
                     timerLoad <= 1'b0;
                  end else if (mode == `MODE_BOTH_OFF || modeReg != `MODE_BOTH_OFF) begin
                     stateReg <= ST_CCP;
                     timerValue <= {1'b0, ccpTime};
                  end else begin
                     stateReg <= ST_BLANK;
                     timerValue <= 9'(blankTime) + 9'(drain_source_filter_time);
                  end
               end else if (timerDone) begin
                  unique case (stateReg)
                     ST_CCP: begin
                        if (modeReg == `MODE_BOTH_OFF) begin
                           stateReg <= ST_HOLD;
                        end else begin
                           stateReg <= ST_BLANK;
                           timerLoad <= 1'b1;
                           timerValue <= 9'(blankTime) + 9'(drain_source_filter_time);
                        end
                     end
                     ST_BLANK: stateReg <= ST_HOLD;
                     ST_IDLE, ST_HOLD: stateReg <= stateReg;
                     ST_PWM: stateReg <= ST_IDLE;
                  endcase
               end
            end
         end

         // Output drive per state; both sides share one step except in ST_BLANK
         always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
               highKind[b] <= DRV_PASSIVE;
               lowKind[b] <= DRV_PASSIVE;
               highStep[b] <= 6'h00;
               lowStep[b] <= 6'h00;
               ccpInsert[b] <= 1'b0;
               prechargeActive[b] <= 1'b0;
               busy[b] <= 1'b0;
            end else begin
               ccpInsert[b] <= (stateReg == ST_PWM) & active_freewheel_en[b];
               prechargeActive[b] <= (stateReg == ST_PWM) & preAct;
               busy[b] <= (stateReg == ST_CCP) | (stateReg == ST_BLANK);
               unique case (stateReg)
                  ST_IDLE: begin
                     highKind[b] <= DRV_PASSIVE;
                     lowKind[b] <= DRV_PASSIVE;
                     highStep[b] <= 6'h00;
                     lowStep[b] <= 6'h00;
                  end
                  ST_CCP: begin
                     highKind[b] <= DRV_SINK;
                     lowKind[b] <= DRV_SINK;
                     highStep[b] <= staticStep;
                     lowStep[b] <= staticStep;
                  end
                  ST_BLANK: begin
                     highKind[b] <= (modeReg == `MODE_HS_ON) ? DRV_CHARGE : DRV_SINK;
                     lowKind[b] <= (modeReg == `MODE_LS_ON) ? DRV_CHARGE : DRV_SINK;
                     highStep[b] <= (modeReg == `MODE_HS_ON) ? staticStep : `HARD_OFF_STEP;
                     lowStep[b] <= (modeReg == `MODE_LS_ON) ? staticStep : `HARD_OFF_STEP;
                  end
                  ST_HOLD: begin
                     highKind[b] <= (modeReg == `MODE_HS_ON) ? DRV_CHARGE : DRV_SINK;
                     lowKind[b] <= (modeReg == `MODE_LS_ON) ? DRV_CHARGE : DRV_SINK;
                     highStep[b] <= holdStep;
                     lowStep[b] <= holdStep;
                  end
                  ST_PWM: begin
                     highKind[b] <= pwmHs ? DRV_CHARGE : DRV_SINK;
                     lowKind[b] <= pwmLs ? DRV_CHARGE : DRV_SINK;
                     highStep[b] <= preAct ? preStep : staticStep;
                     lowStep[b] <= preAct ? preStep : staticStep;
                  end
               endcase
            end
         end
      end
   endgenerate
endmodule

// ### half_bridge_load.sv
// Behavioural half-bridge load: switch node comparators from the gate drive.
// Assumes drive kinds registered on core_clk; comparators answer one cycle late.
`timescale 1ns/1ps
module half_bridge_load
   import gate_seq_pkg::*;
(
   input  wire logic        core_clk,
   input  drive_kind_t      highKind [3],
   input  drive_kind_t      lowKind  [3],
   output logic [2:0]       switchNodeAbove,
   output logic [2:0]       switchNodeBelow
);
   always_ff @(posedge core_clk) begin
      for (int b = 0; b < 3; b++) begin
         // Shoot-through (both charging) leaves the node between thresholds
         switchNodeAbove[b] <= highKind[b] == DRV_CHARGE && lowKind[b] != DRV_CHARGE;
         switchNodeBelow[b] <= lowKind[b] == DRV_CHARGE && highKind[b] != DRV_CHARGE;
      end
   end
endmodule

// ### phase_timer.sv
// Down-counter timing one static phase, loaded with a configured duration.
// Assumes a load pulse and duration from the same clock.
`timescale 1ns/1ps
`include "gate_seq_regs.svh"
module phase_timer (
   input  wire logic                core_clk,
   input  wire logic                rst_n,
   input  wire logic                load,
   input  wire logic [`DUR_W:0]     loadValue,
   output logic                     done
);
   logic [`DUR_W:0] countReg;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n)
         countReg <= '0;
      else if (load)
         countReg <= loadValue;
      else if (countReg != '0)
         countReg <= countReg - 1'b1;
   end
   assign done = (countReg == '0) & ~load;
endmodule

// ### pwm_side_select.sv
// Per half-bridge PWM decision: active side, free-wheel, pre-charge current.
// Assumes synchronised PWM and comparator inputs on core_clk.
`timescale 1ns/1ps
`include "gate_seq_regs.svh"
module pwm_side_select (
   input  wire logic       core_clk,
   input  wire logic       rst_n,
   input  wire logic       pwmHigh,
   input  wire logic       pwmLow,
   input  wire logic       swAbove,
   input  wire logic       swBelow,
   input  wire logic       activeSideDetectEn,
   input  wire logic       freewheelEn,
   input  wire logic       pwmCountSel,
   input  wire logic [1:0] gateControlScheme,
   input  wire logic [5:0] prechargeInit,
   input  wire logic [5:0] predischargeInit,
   output logic            hsOn,
   output logic            lsOn,
   output logic            preActive,
   output logic [5:0]      preStep
);
   logic activeHsReg;
   logic [5:0] adaptStepReg;
   logic afw;
   logic pwmOn;
   logic pwmRise;
   logic pwmPrevReg;
   assign afw = freewheelEn & ~pwmCountSel;
   assign pwmOn = pwmHigh | (pwmCountSel ? 1'b0 : pwmLow);
   assign pwmRise = pwmOn & ~pwmPrevReg;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pwmPrevReg <= 1'b0;
         activeHsReg <= 1'b1;
      end else begin
         pwmPrevReg <= pwmOn;
         if (pwmRise) begin
            if (!activeSideDetectEn)
               activeHsReg <= pwmHigh;
            else if (swAbove)
               activeHsReg <= 1'b0;
            else if (swBelow)
               activeHsReg <= 1'b1;
            else
               activeHsReg <= pwmHigh;
         end
      end
   end
   // Adaptive step loads prechargeInit on the first rising PWM edge, then rises one step per edge up to 3F; delay sensing is analogue, kept simple here
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         adaptStepReg <= 6'h00;
      end else begin
         if (gateControlScheme[1] && pwmRise) begin
            if (adaptStepReg == 6'h00)
               adaptStepReg <= prechargeInit;
            else if (adaptStepReg != `HARD_OFF_STEP)
               adaptStepReg <= adaptStepReg + 6'h01;
         end
      end
   end
   always_comb begin
      hsOn = activeHsReg ? pwmOn : (afw & ~pwmOn);
      lsOn = activeHsReg ? (afw & ~pwmOn) : pwmOn;
      preActive = (gateControlScheme != `AGC_NONE);
      if (gateControlScheme == `AGC_FIXED)
         preStep = pwmOn ? prechargeInit : predischargeInit;
      else
         preStep = adaptStepReg;
   end
endmodule

// ### tb.sv
// Testbench: static commands on bridge 0, PWM traffic on bridge 1.
// Assumes the sequencer, the load model and the bound checker.
`timescale 1ns/1ps
module tb;
   import gate_seq_pkg::*;
   logic        core_clk, rst_n, chipSelect, charge_pump_on, hold_current_select;
   logic        active_side_detect_en, pwm_input_count_sel, watch;
   logic [5:0]  half_bridge_drive_select, pwmIn;
   logic [2:0]  bridge_pwm_select, active_freewheel_en, switchNodeAbove, switchNodeBelow;
   logic [2:0]  ccpInsert, prechargeActive, busy;
   logic [11:0] static_gate_current_code;
   logic [1:0]  gate_control_scheme;
   logic [17:0] precharge_init_current, predischarge_init_current, prev, cur;
   logic [7:0]  ccpTime, blankTime, drain_source_filter_time, lfsr, pw;
   drive_kind_t highKind [3];
   drive_kind_t lowKind  [3];
   logic [5:0]  highStep [3];
   logic [5:0]  lowStep  [3];
   logic [17:0] notes [$];
   int          num_errors, checks, cycles;
   half_bridge_gate_sequencer u_half_bridge_gate_sequencer (.*);
   half_bridge_load u_half_bridge_load (.core_clk(core_clk), .highKind(highKind),
      .lowKind(lowKind), .switchNodeAbove(switchNodeAbove), .switchNodeBelow(switchNodeBelow));
   function automatic logic [7:0] lfsr_step(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   function automatic logic [17:0] tup(input drive_kind_t kh, input drive_kind_t kl,
                                       input logic [5:0] sh, input logic [5:0] sl);
      return {kh, kl, sh, sl};
   endfunction
   task automatic check(input string name, input logic [17:0] exp, input logic [17:0] got);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %s exp %h got %h", name, exp, got);
      end
   endtask
   task automatic stop_test();
      $display("errors %0d checks %0d", num_errors, checks);
      if (num_errors == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // Notes every drive change bridge 0 must show, then waits for them all
   task automatic command(input logic [1:0] mode, input bit ccp);
      logic [3:0] code;
      logic [5:0] s, h;
      int         n;
      lfsr = lfsr_step(lfsr);
      code = 4'h6 + 4'(lfsr % 8'h0A);
      s = {code, 2'h0};
      h = hold_current_select ? 6'h14 : 6'h0F;
      @(negedge core_clk);
      chipSelect = 1'b0;
      static_gate_current_code = {lfsr, code};
      half_bridge_drive_select[1:0] = mode;
      if (ccp) notes.push_back(tup(DRV_SINK, DRV_SINK, s, s));
      case (mode)
         2'h1: begin
            notes.push_back(tup(DRV_SINK, DRV_CHARGE, 6'h3F, s));
            notes.push_back(tup(DRV_SINK, DRV_CHARGE, h, h));
         end
         2'h2: begin
            notes.push_back(tup(DRV_CHARGE, DRV_SINK, s, 6'h3F));
            notes.push_back(tup(DRV_CHARGE, DRV_SINK, h, h));
         end
         default: notes.push_back(tup(DRV_SINK, DRV_SINK, h, h));
      endcase
      @(negedge core_clk);
      chipSelect = 1'b1;
      n = 0;
      while (notes.size() != 0 && n < 200) begin
         @(negedge core_clk);
         n++;
      end
      if (notes.size() != 0) begin
         num_errors++;
         $display("BAD pending exp 0 got %0d", notes.size());
         notes.delete();
      end
      repeat (20) @(negedge core_clk);
   endtask
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   always @(negedge core_clk) begin
      cur = {highKind[0], lowKind[0], highStep[0], lowStep[0]};
      if (rst_n && watch && cur !== prev) begin
         if (notes.size() == 0) check("unexpected", prev, cur);
         else check("bridge0", notes.pop_front(), cur);
      end
      prev = cur;
      if (cycles % 8 == 0) begin
         pw = lfsr_step(pw);
         pwmIn <= {2'h0, pw[1:0], 2'h0};
      end
   end
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 5000) begin
         num_errors++;
         stop_test();
      end
   end
   initial begin
      {rst_n, chipSelect, charge_pump_on, hold_current_select, watch} = 5'h0;
      {active_side_detect_en, pwm_input_count_sel, gate_control_scheme} = 4'h0;
      {half_bridge_drive_select, pwmIn, active_freewheel_en} = 15'h0;
      {static_gate_current_code, precharge_init_current, predischarge_init_current} = 48'h0;
      bridge_pwm_select = 3'h2;
      {ccpTime, blankTime, drain_source_filter_time} = {8'h04, 8'h03, 8'h02};
      {lfsr, pw, prev} = {8'h3F, 8'h3F, 18'h0};
      {num_errors, checks, cycles} = 0;
      for (int p = 0; p < 2; p++) begin
         @(negedge core_clk);
         {rst_n, watch} = 2'h0;
         notes.delete();
         hold_current_select = p[0];
         active_side_detect_en = p[0];
         pwm_input_count_sel = p[0];
         active_freewheel_en = p[0] ? 3'h0 : 3'h2;
         gate_control_scheme = p[0] ? 2'h1 : 2'h0;
         precharge_init_current = {12'h0, lfsr[5:0]};
         predischarge_init_current = {12'h0, pw[5:0]};
         {charge_pump_on, half_bridge_drive_select} = 7'h40;
         repeat (6) @(negedge core_clk);
         {rst_n, watch} = 2'h3;
         command(2'h1, 1'b1);
         command(2'h2, 1'b1);
         command(2'h3, 1'b1);
         command(2'h2, 1'b0);
         command(2'h3, 1'b1);
         command(2'h1, 1'b0);
         check("pwm_flags", {12'h0, 1'b0, ~p[0], 2'h0, p[0], 1'b0},
               {12'h0, ccpInsert, prechargeActive});
         {watch, charge_pump_on, chipSelect} = 3'h0;
         repeat (3) @(negedge core_clk);
         chipSelect = 1'b1;
         repeat (6) @(negedge core_clk);
         check("pump_off", {6'h0, DRV_PASSIVE, DRV_PASSIVE, DRV_PASSIVE, DRV_PASSIVE},
               {6'h0, highKind[0], lowKind[0], highKind[2], lowKind[2]});
      end
      stop_test();
   end
endmodule
